// file: hw/vps_pin_ctrl.sv
// control and status pin logic of a triaxial vibration sensor module
// Behaviour
// - trigger edge sensitive in manual modes, level sensitive in streaming/auto, enabled by control bit twelve
// - manual modes: rising trigger edge starts capture
// - streaming/auto: convert while trigger high, finish record
// - streaming: busy low while loading, high when ready
// - other modes: refuse port, busy while executing
// - completion releases port, busy output goes high
// - escape write 0x00e8 accepted while executing a command or capturing, aborts
// - alarm pins from alarm control, off in streaming
// - supply monitor low on overtemperature shutdown
// - reset low: known state, reload parameters
`timescale 1ns/100ps
module vps_pin_ctrl #(
  parameter int unsigned CMD_CYC    = vps_pkg::VPS_CMD_CYC_DEF,
  parameter int unsigned REC_CYC    = vps_pkg::VPS_REC_CYC_DEF,
  parameter int unsigned LOAD_CYC   = vps_pkg::VPS_LOAD_CYC_DEF,
  parameter int unsigned RELOAD_CYC = vps_pkg::VPS_RELOAD_CYC_DEF
) (
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        RESET_N,
  input  wire logic        TRIGGER,
  input  wire logic [15:0] MISC_CONTROL,
  input  wire logic [1:0]  MODE,
  input  wire logic        CMD_VALID,
  input  wire logic [15:0] CMD_DATA,
  input  wire logic [1:0]  ALARM_CONTROL,
  input  wire logic [1:0]  ALARM_EVENT,
  input  wire logic        OVER_TEMP,
  output logic             BUSY,
  output logic             PORT_REFUSE,
  output logic             CMD_ACCEPT,
  output logic             CAPTURE_DONE,
  output logic             CONVERTING,
  output logic             RELOAD_ACTIVE,
  output logic             ALARM_OUT_ONE,
  output logic             ALARM_OUT_TWO,
  output logic             SUPPLY_MONITOR_OUT
);

  // trigger synchroniser; stage zero read only by stage one
  logic [vps_pkg::VPS_SYNC_STAGES-1:0] trig_sync_q;
  logic                                trig_prev_q;   // edge history
  logic [vps_pkg::VPS_CNT_W-1:0]       cnt_q;         // work counter
  logic [vps_pkg::VPS_CNT_W-1:0]       cnt_d;
  vps_pkg::vps_state_t                 state_q;
  vps_pkg::vps_state_t                 state_d;
  logic                                rst_n_q;       // reset pin history
  logic                                stop_q;        // stop after record
  logic                                stop_d;

  // decoded conditions
  wire trig_lvl    = trig_sync_q[vps_pkg::VPS_SYNC_STAGES-1];
  wire trig_en     = MISC_CONTROL[vps_pkg::VPS_TRIG_EN_BIT];
  wire trig_rise   = trig_en & trig_lvl & ~trig_prev_q;
  wire mode_manual = (MODE == vps_pkg::VPS_MODE_MTC) |
                     (MODE == vps_pkg::VPS_MODE_MANUAL_SPECTRUM_MODE);
  wire mode_rts    = (MODE == vps_pkg::VPS_MODE_RTS);
  wire mode_level  = mode_rts | (MODE == vps_pkg::VPS_MODE_AUTOMATIC_SPECTRUM_MODE);
  wire run_level   = trig_en & trig_lvl;
  wire is_escape   = CMD_VALID & (CMD_DATA == vps_pkg::VPS_CMD_ESCAPE);
  wire is_capture  = CMD_VALID & (CMD_DATA == vps_pkg::VPS_CMD_CAPTURE);
  wire reset_fall  = rst_n_q & ~RESET_N;
  wire cnt_zero    = (cnt_q == '0);
  wire busy_state  = (state_q == vps_pkg::VPS_ST_CMD) |
                     (state_q == vps_pkg::VPS_ST_CAP) |
                     (state_q == vps_pkg::VPS_ST_RELOAD);
  // commands only taken when idle, or when streaming with data ready
  wire port_open   = (state_q == vps_pkg::VPS_ST_IDLE) |
                     (state_q == vps_pkg::VPS_ST_READY);
  wire cmd_take    = CMD_VALID & port_open & ~is_escape;
  wire escape_take = is_escape & busy_state &
                     (state_q != vps_pkg::VPS_ST_RELOAD);
  wire start_cap   = (mode_manual & (trig_rise | is_capture)) |
                     (mode_level & run_level);

  // counter load value, cut to counter width
  function automatic logic [vps_pkg::VPS_CNT_W-1:0] cyc(
    input int unsigned n
  );
    cyc = vps_pkg::VPS_CNT_W'(n - 1);
  endfunction

  // synchroniser and edge history
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      trig_sync_q <= '0;
      trig_prev_q <= 1'b0;
      rst_n_q     <= 1'b1;
    end else begin
      trig_sync_q <= {trig_sync_q[vps_pkg::VPS_SYNC_STAGES-2:0],
                      TRIGGER};
      trig_prev_q <= trig_lvl;
      rst_n_q     <= RESET_N;
    end
  end

  // next state; reset pin overrides everything
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_zero ? cnt_q : cnt_q - 1'b1;
    stop_d  = stop_q;
    if (!RESET_N || reset_fall) begin
      // hold known state while the pin is low
      state_d = vps_pkg::VPS_ST_RELOAD;
      cnt_d   = cyc(RELOAD_CYC);
      stop_d  = 1'b0;
    end else begin
      unique case (state_q)
        vps_pkg::VPS_ST_IDLE: begin
          if (start_cap && (mode_manual || run_level)) begin
            state_d = mode_rts ? vps_pkg::VPS_ST_LOAD
                               : vps_pkg::VPS_ST_CAP;
            cnt_d   = mode_rts ? cyc(LOAD_CYC) : cyc(REC_CYC);
            stop_d  = 1'b0;
          end else if (cmd_take && !mode_rts) begin
            state_d = vps_pkg::VPS_ST_CMD;
            cnt_d   = cyc(CMD_CYC);
          end
        end
        vps_pkg::VPS_ST_CMD: begin
          if (escape_take || cnt_zero)
            state_d = vps_pkg::VPS_ST_IDLE;
        end
        vps_pkg::VPS_ST_CAP: begin
          if (escape_take) begin
            state_d = vps_pkg::VPS_ST_IDLE;
          end else if (cnt_zero) begin
            // level modes keep recording while trigger held
            if (mode_level && run_level) begin
              cnt_d = cyc(REC_CYC);
            end else begin
              state_d = vps_pkg::VPS_ST_IDLE;
            end
          end
        end
        vps_pkg::VPS_ST_LOAD: begin
          if (cnt_zero) begin
            state_d = vps_pkg::VPS_ST_READY;
            cnt_d   = cyc(REC_CYC);
          end
        end
        vps_pkg::VPS_ST_READY: begin
          // remember a stop request, honour it at record end
          if (!run_level) stop_d = 1'b1;
          if (cnt_zero) begin
            if (stop_q || !run_level || !mode_rts) begin
              state_d = vps_pkg::VPS_ST_IDLE;
            end else begin
              state_d = vps_pkg::VPS_ST_LOAD;
              cnt_d   = cyc(LOAD_CYC);
            end
          end
        end
        vps_pkg::VPS_ST_RELOAD: begin
          if (cnt_zero) state_d = vps_pkg::VPS_ST_IDLE;
        end
        default: state_d = vps_pkg::VPS_ST_IDLE;
      endcase
    end
  end

  // state registers
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_q <= vps_pkg::VPS_ST_RELOAD;
      cnt_q   <= cyc(RELOAD_CYC);
      stop_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      stop_q  <= stop_d;
    end
  end

  // registered outputs; alarms silenced in streaming mode
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      BUSY               <= 1'b0;
      PORT_REFUSE        <= 1'b1;
      CMD_ACCEPT         <= 1'b0;
      CAPTURE_DONE       <= 1'b0;
      CONVERTING         <= 1'b0;
      RELOAD_ACTIVE      <= 1'b1;
      ALARM_OUT_ONE      <= vps_pkg::VPS_ALARM_RST[0];
      ALARM_OUT_TWO      <= vps_pkg::VPS_ALARM_RST[1];
      SUPPLY_MONITOR_OUT <= 1'b1;
    end else begin
      // busy low while executing or loading buffers
      BUSY          <= (state_d == vps_pkg::VPS_ST_IDLE) |
                       (state_d == vps_pkg::VPS_ST_READY);
      PORT_REFUSE   <= ~((state_d == vps_pkg::VPS_ST_IDLE) |
                         (state_d == vps_pkg::VPS_ST_READY));
      CMD_ACCEPT    <= RESET_N & (cmd_take | escape_take);
      CAPTURE_DONE  <= RESET_N & (state_q == vps_pkg::VPS_ST_CAP) &
                       (state_d == vps_pkg::VPS_ST_IDLE);
      CONVERTING    <= (state_d == vps_pkg::VPS_ST_CAP) |
                       (state_d == vps_pkg::VPS_ST_LOAD) |
                       (state_d == vps_pkg::VPS_ST_READY);
      RELOAD_ACTIVE <= (state_d == vps_pkg::VPS_ST_RELOAD);
      ALARM_OUT_ONE <= ~mode_rts & ALARM_CONTROL[0] &
                       ALARM_EVENT[0];
      ALARM_OUT_TWO <= ~mode_rts & ALARM_CONTROL[1] &
                       ALARM_EVENT[1];
      SUPPLY_MONITOR_OUT <= ~OVER_TEMP;
    end
  end

endmodule

// file: shared/vps_pkg.sv
// constants and types for the vibration sensor pin trigger and status block
package vps_pkg;
  // capture modes (low two bits of the record control field)
  typedef enum logic [1:0] {
    VPS_MODE_MTC  = 2'b00, // manual_time_capture_mode
    VPS_MODE_MANUAL_SPECTRUM_MODE = 2'b01, // manual_spectrum_mode
    VPS_MODE_AUTOMATIC_SPECTRUM_MODE = 2'b10, // automatic_spectrum_mode
    VPS_MODE_RTS  = 2'b11  // real-time streaming
  } vps_mode_t;

  // controller state
  typedef enum logic [2:0] {
    VPS_ST_IDLE   = 3'b000, // ready, port released
    VPS_ST_CMD    = 3'b001, // command executing
    VPS_ST_CAP    = 3'b010, // record capture running
    VPS_ST_LOAD   = 3'b011, // streaming: loading output buffers
    VPS_ST_READY  = 3'b100, // streaming: data ready for readout
    VPS_ST_RELOAD = 3'b101  // reload of parameters after reset
  } vps_state_t;

  localparam int unsigned VPS_TRIG_EN_BIT     = 12;
  localparam logic [15:0] VPS_CMD_CAPTURE     = 16'h0800;
  localparam logic [15:0] VPS_CMD_ESCAPE      = 16'h00e8;
  localparam int unsigned VPS_SYNC_STAGES     = 2;
  localparam int unsigned VPS_CLK_MHZ         = 25;
  // least trigger pulse width 50 ns, rounded up to cycles
  localparam int unsigned VPS_SYNC_MIN_NS     = 50;
  localparam int unsigned VPS_SYNC_MIN_CYC    =
    (VPS_SYNC_MIN_NS * VPS_CLK_MHZ + 999) / 1000;
  // default lengths in cycles of simulated internal work
  localparam int unsigned VPS_CMD_CYC_DEF     = 64;
  localparam int unsigned VPS_REC_CYC_DEF     = 256;
  localparam int unsigned VPS_LOAD_CYC_DEF    = 16;
  localparam int unsigned VPS_RELOAD_CYC_DEF  = 128;
  localparam int unsigned VPS_CNT_W           = 16;
  localparam logic [1:0]  VPS_ALARM_RST       = 2'b00;
endpackage

// file: testbench/vps_host_model.sv
// host side trigger driver keeping the least pulse width
`timescale 1ns/100ps
module vps_host_model (
  input wire logic CLOCK,
  input wire logic TRIG_REQ,
  output logic     TRIGGER
);
  logic [3:0] hold_q; // cycles left before the pin may change again
  initial begin
    TRIGGER = 1'b0;
    hold_q = 4'h0;
  end
  // host edges land between device edges; each level stays long enough
  always @(negedge CLOCK) begin
    if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end else if (TRIG_REQ != TRIGGER) begin
      TRIGGER <= TRIG_REQ;
      hold_q <= 4'(vps_pkg::VPS_SYNC_MIN_CYC);
    end
  end
endmodule

// file: testbench/vps_pin_ctrl_chk.sv
// port assertions for the pin trigger and status controller
`timescale 1ns/100ps
module vps_pin_ctrl_chk (
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire logic        RESET_N,
  input wire logic [1:0]  MODE,
  input wire logic        CMD_VALID,
  input wire logic [15:0] CMD_DATA,
  input wire logic [1:0]  ALARM_CONTROL,
  input wire logic [1:0]  ALARM_EVENT,
  input wire logic        OVER_TEMP,
  input wire logic        BUSY,
  input wire logic        PORT_REFUSE,
  input wire logic        CMD_ACCEPT,
  input wire logic        CAPTURE_DONE,
  input wire logic        CONVERTING,
  input wire logic        RELOAD_ACTIVE,
  input wire logic        ALARM_OUT_ONE,
  input wire logic        SUPPLY_MONITOR_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // refusal flag must mirror busy at all times
  a_refuse_mirrors_busy: assert property (PORT_REFUSE == !BUSY)
    else $error("refuse not inverse of busy");
  // a command taken while ready starts work next cycle
  a_cmd_taken_ready: assert property (CMD_VALID && BUSY && RESET_N
    && !RELOAD_ACTIVE
    && !MODE[1] && CMD_DATA != vps_pkg::VPS_CMD_ESCAPE |=> CMD_ACCEPT && !BUSY)
    else $error("command not taken");
  // only the escape word gets through while busy
  a_busy_drops_cmd: assert property (CMD_VALID && !BUSY
    && CMD_DATA != vps_pkg::VPS_CMD_ESCAPE |=> !CMD_ACCEPT)
    else $error("command taken while busy");
  // escape ends a manual capture one cycle later
  a_escape_aborts: assert property (CMD_VALID && CONVERTING && RESET_N
    && !MODE[1]
    && CMD_DATA == vps_pkg::VPS_CMD_ESCAPE |=> BUSY && CAPTURE_DONE)
    else $error("escape did not abort");
  // end of a record releases the port at once
  a_done_releases: assert property (CAPTURE_DONE && !MODE[1] |-> BUSY)
    else $error("done without busy high");
  // alarm pin follows its enable, silent in streaming
  a_alarm_gated: assert property (!$past(SRST) |-> ALARM_OUT_ONE ==
    ($past(ALARM_CONTROL[0] & ALARM_EVENT[0]) && $past(MODE) != 2'b11))
    else $error("alarm one wrong");
  // overtemperature pulls the monitor low a cycle later
  a_monitor_low: assert property (!$past(SRST) |->
    SUPPLY_MONITOR_OUT == !$past(OVER_TEMP))
    else $error("supply monitor wrong");
  // hardware reset holds the reload state, port refused
  a_reset_reloads: assert property (!RESET_N [*3] |=> RELOAD_ACTIVE && !BUSY)
    else $error("reset did not reload");
endmodule
bind vps_pin_ctrl vps_pin_ctrl_chk u_chk (.CLOCK(CLOCK), .SRST(SRST),
  .RESET_N(RESET_N), .MODE(MODE), .CMD_VALID(CMD_VALID), .CMD_DATA(CMD_DATA),
  .ALARM_CONTROL(ALARM_CONTROL), .ALARM_EVENT(ALARM_EVENT),
  .OVER_TEMP(OVER_TEMP), .BUSY(BUSY), .PORT_REFUSE(PORT_REFUSE),
  .CMD_ACCEPT(CMD_ACCEPT), .CAPTURE_DONE(CAPTURE_DONE),
  .CONVERTING(CONVERTING), .RELOAD_ACTIVE(RELOAD_ACTIVE),
  .ALARM_OUT_ONE(ALARM_OUT_ONE), .SUPPLY_MONITOR_OUT(SUPPLY_MONITOR_OUT));

// file: testbench/vps_pin_ctrl_test.sv
// self-checking bench for the pin trigger and status controller
`timescale 1ns/100ps
module vps_pin_ctrl_test;
  localparam int REC = 6; // short record so the run stays brief
  localparam int LD = 4;
  localparam int RLD = 5;
  logic clk = 0, srst = 1, rst_n = 1, trq = 0, trig, cv = 0, ot = 0;
  logic [15:0] misc = 16'h0000, cd = 16'h0000;
  logic [1:0] mode = 2'h0, ac = 2'h0, ae = 2'h0;
  logic busy, rfs, acc, done, conv, rld, al1, al2, smon;
  logic sa, sd; // accept and done pulses seen in the answer cycle
  int n_errors = 0, n_checks = 0, cyc = 0, k;
  always #20 clk = ~clk;
  vps_host_model host (.CLOCK(clk), .TRIG_REQ(trq), .TRIGGER(trig));
  vps_pin_ctrl #(.CMD_CYC(4), .REC_CYC(REC), .LOAD_CYC(LD), .RELOAD_CYC(RLD))
    dut (.CLOCK(clk), .SRST(srst), .RESET_N(rst_n), .TRIGGER(trig),
    .MISC_CONTROL(misc), .MODE(mode), .CMD_VALID(cv), .CMD_DATA(cd),
    .ALARM_CONTROL(ac), .ALARM_EVENT(ae), .OVER_TEMP(ot), .BUSY(busy),
    .PORT_REFUSE(rfs), .CMD_ACCEPT(acc), .CAPTURE_DONE(done),
    .CONVERTING(conv), .RELOAD_ACTIVE(rld), .ALARM_OUT_ONE(al1),
    .ALARM_OUT_TWO(al2), .SUPPLY_MONITOR_OUT(smon));
  task automatic chk(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  // one-cycle write; pulses are caught while they stand, then a spare cycle
  // keeps the strobe from being lowered and raised in one time step
  task automatic cmd(input logic [15:0] d, output logic a, output logic dn);
    cv = 1;
    cd = d;
    @(negedge clk);
    a = acc;
    dn = done;
    cv = 0;
    @(negedge clk);
  endtask
  // bounded wait for a busy level
  task automatic wait_busy(input logic lvl, input int lim);
    for (k = 0; busy !== lvl && k < lim; k++) @(negedge clk);
    chk("busy", lvl, busy);
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    srst = 0;
    wait_busy(1, RLD + 8);
    cmd(vps_pkg::VPS_CMD_CAPTURE, sa, sd);
    chk("accept", 1, sa);
    chk("refuse", 1, rfs);
    chk("converting", 1, conv);
    cmd(16'h0001, sa, sd);
    chk("dropped", 0, sa);
    cmd(vps_pkg::VPS_CMD_ESCAPE, sa, sd);
    chk("escape busy", 1, busy);
    chk("escape done", 1, sd);
    cmd(vps_pkg::VPS_CMD_CAPTURE, sa, sd);
    @(negedge clk);
    wait_busy(1, REC + 4);
    chk("done", 1, done);
    mode = 2'h1; // trigger held off by the enable bit
    trq = 1;
    repeat (8) @(negedge clk);
    chk("disabled", 1, busy);
    trq = 0;
    misc[vps_pkg::VPS_TRIG_EN_BIT] = 1;
    repeat (4) @(negedge clk);
    trq = 1;
    wait_busy(0, 8);
    wait_busy(1, REC + 4);
    repeat (8) @(negedge clk);
    chk("level ignored", 1, busy);
    trq = 0;
    ac = 2'h3; // streaming with alarms raised
    ae = 2'h3;
    // let the trigger settle low before a level mode can see it
    repeat (4) @(negedge clk);
    mode = 2'h3;
    trq = 1;
    wait_busy(0, 10);
    chk("alarm one", 0, al1);
    chk("alarm two", 0, al2);
    wait_busy(1, LD + 4);
    wait_busy(0, REC + 4);
    trq = 0;
    repeat (2 * (LD + REC) + 8) @(negedge clk);
    chk("stopped", 1, busy);
    chk("conv off", 0, conv);
    mode = 2'h0;
    ac = 2'h1;
    ot = 1;
    repeat (2) @(negedge clk);
    chk("alarm one", 1, al1);
    chk("alarm two", 0, al2);
    chk("monitor", 0, smon);
    ot = 0;
    rst_n = 0;
    repeat (4) @(negedge clk);
    chk("reload", 1, rld);
    rst_n = 1;
    wait_busy(1, RLD + 8);
    wrap_up();
  end
endmodule
